// file: core/urcg_top.sv
// status-byte scheduler and builder facing the link over the 8-bit bus
// Notes on behaviour
// - line state, receive events, vbus level and id are all reported to the link in the status byte.
// - a status byte is driven only in synchronous mode while dir is high and past the turnaround.
// - a line-state change while dir is low makes the device take the bus and send a status byte at once.
// - during a receive, every owned cycle without a data byte carries a status byte with nxt low.
// - during a transmit status bytes are held back until the link raises stp, then one is sent.
// - any change of the encoded vbus level or the id level causes a fresh status byte.
// - after start-up, once dir has dropped and stp is seen low, a status byte is sent.
// - on return to synchronous mode after the link's stp exit request, a status byte is sent.
// - bits 1:0 carry the current line state.
// - bits 5:4 encode receive events, 00 meaning no activity, no error and no disconnect.
// - line state bit 0 follows the dp receiver and bit 1 the dm receiver.
// - bit 6 is the id level, low for an a-device and high for a b-device.
// - bit 7 is set while an unmasked alternate interrupt is latched.
// - every dir change is followed by one turnaround cycle with nobody driving and the bus ignored.
module urcg_top (
   input  wire logic                         clk_i,
   input  wire logic                         sys_rst_i,
   // link side of the bus
   input  wire logic                         ulpi_stp_i,
   input  wire logic [urcg_pkg::URCG_W-1:0]  ulpi_data_i,
   output logic [urcg_pkg::URCG_W-1:0]       ulpi_data_o,
   output logic                              ulpi_data_oe_n_o,
   output logic                              ulpi_dir_o,
   output logic                              ulpi_nxt_o,
   // mode and sequencing inputs
   input  wire logic                         startup_i,
   input  wire logic                         sync_mode_i,
   input  wire logic                         lp_exit_i,
   input  wire logic                         tx_active_i,
   // line and comparator inputs
   input  wire logic                         dp_rcv_i,
   input  wire logic                         dm_rcv_i,
   input  wire logic                         sess_end_i,
   input  wire logic                         sess_vld_i,
   input  wire logic                         vbus_vld_i,
   input  wire logic                         id_i,
   input  wire logic                         alt_int_i,
   // receiver
   input  wire logic                         rx_active_i,
   input  wire logic                         rx_error_i,
   input  wire logic                         host_disc_i,
   input  wire logic                         rx_valid_i,
   input  wire logic [urcg_pkg::URCG_W-1:0]  rx_data_i,
   output logic                              rx_ready_o,
   // link bytes seen while the link owns the bus
   output logic [urcg_pkg::URCG_W-1:0]       link_byte_o,
   output logic                              link_byte_valid_o
);
   import urcg_pkg::*;

   urcg_state_t       state_reg;
   urcg_state_t       state_next;
   logic              dir_reg;
   logic              dir_next;
   logic              nxt_reg;
   logic              nxt_next;
   logic [URCG_W-1:0] data_reg;
   logic [URCG_W-1:0] data_next;
   logic              oe_n_reg;
   logic              oe_n_next;
   logic              pend_reg;
   logic              tx_hold_reg;
   logic              boot_wait_reg;
   logic [1:0]        ls_prev_reg;
   logic [1:0]        vbus_prev_reg;
   logic [1:0]        evt_prev_reg;
   logic              id_prev_reg;
   logic [URCG_W-1:0] link_byte_reg;
   logic              link_valid_reg;

   logic [1:0]        line_state;
   logic [1:0]        vbus_enc;
   logic [1:0]        evt_enc;
   logic [URCG_W-1:0] status_byte;
   logic              sent;
   logic              trig;
   logic              stp_after_tx;
   logic              boot_trig;
   logic              want_bus;
   logic              buf_valid;
   logic [URCG_W-1:0] buf_data;
   logic              buf_pop;

   urcg_rx_buf urcg_rx_buf_inst (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (rx_valid_i),
      .in_data_i   (rx_data_i),
      .in_ready_o  (rx_ready_o),
      .out_valid_o (buf_valid),
      .out_data_o  (buf_data),
      .out_ready_i (buf_pop)
   );

   assign line_state = {dm_rcv_i, dp_rcv_i};

   always_comb begin
      // highest comparator wins; lower ones are don't-care above it
      if (vbus_vld_i) begin
         vbus_enc = VBUS_ABOVE_VV;
      end else if (sess_vld_i) begin
         vbus_enc = VBUS_SV_TO_VV;
      end else if (!sess_end_i) begin
         vbus_enc = VBUS_END_TO_SV;
      end else begin
         vbus_enc = VBUS_BELOW_END;
      end
   end

   always_comb begin
      if (rx_active_i && rx_error_i) begin
         evt_enc = EVT_ERROR;
      end else if (rx_active_i) begin
         evt_enc = EVT_ACTIVE;
      end else if (host_disc_i) begin
         evt_enc = EVT_HOSTDISC;
      end else begin
         evt_enc = EVT_NONE;
      end
   end

   always_comb begin
      status_byte                          = DATA_RST;
      status_byte[LS_LSB+1:LS_LSB]        = line_state;
      status_byte[VBUS_LSB+1:VBUS_LSB]    = vbus_enc;
      status_byte[EVT_LSB+1:EVT_LSB]      = evt_enc;
      status_byte[ID_BIT]                  = id_i;
      status_byte[ALT_BIT]                 = alt_int_i;
   end

   assign stp_after_tx = tx_hold_reg && ulpi_stp_i && !dir_reg;
   assign boot_trig    = boot_wait_reg && (state_reg == ST_IDLE) && !ulpi_stp_i;

   // any trigger only marks a byte as owed; the byte itself is built when sent
   assign trig = (line_state != ls_prev_reg)
              || (vbus_enc != vbus_prev_reg) || (id_i != id_prev_reg)
              || (evt_enc != evt_prev_reg)
              || stp_after_tx || boot_trig
              || lp_exit_i;

   // the stop that ends a transmit hold may take the bus in the same cycle, so the byte is not a cycle late
   assign want_bus = sync_mode_i && (!tx_hold_reg || stp_after_tx) && (pend_reg || trig || rx_active_i);

   always_comb begin
      state_next = state_reg;
      dir_next   = dir_reg;
      nxt_next   = 1'b0;
      data_next  = data_reg;
      oe_n_next  = 1'b1;
      sent       = 1'b0;
      buf_pop    = 1'b0;
      unique case (state_reg)
         ST_START: begin
            dir_next = 1'b1;
            if (!startup_i) begin
               state_next = ST_TURN_DOWN;
               dir_next   = 1'b0;
            end
         end
         ST_IDLE: begin
            dir_next = 1'b0;
            if (want_bus) begin
               state_next = ST_TURN_UP;
               dir_next   = 1'b1;
            end
         end
         ST_TURN_UP: begin
            // turnaround cycle just passed; first owned byte is always a status byte
            state_next = ST_OWN;
            oe_n_next  = 1'b0;
            data_next  = status_byte;
            sent       = 1'b1;
         end
         ST_OWN: begin
            if (!sync_mode_i) begin
               state_next = ST_TURN_DOWN;
               dir_next   = 1'b0;
            end else if (buf_valid) begin
               oe_n_next = 1'b0;
               data_next = buf_data;
               nxt_next  = 1'b1;
               buf_pop   = 1'b1;
            end else if (rx_active_i || pend_reg || trig) begin
               oe_n_next = 1'b0;
               data_next = status_byte;
               sent      = 1'b1;
            end else begin
               state_next = ST_TURN_DOWN;
               dir_next   = 1'b0;
            end
         end
         ST_TURN_DOWN: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_START;
         dir_reg   <= 1'b1;
         nxt_reg   <= 1'b0;
         data_reg  <= DATA_RST;
         oe_n_reg  <= 1'b1;
      end else begin
         state_reg <= state_next;
         dir_reg   <= dir_next;
         nxt_reg   <= nxt_next;
         data_reg  <= data_next;
         oe_n_reg  <= oe_n_next;
      end
   end

   // a trigger in the cycle of a send keeps the byte owed, so nothing is lost
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pend_reg <= 1'b0;
      end else begin
         pend_reg <= trig || (pend_reg && !sent);
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tx_hold_reg <= 1'b0;
      end else begin
         tx_hold_reg <= tx_active_i || (tx_hold_reg && !stp_after_tx);
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         boot_wait_reg <= 1'b0;
      end else if (state_reg == ST_START && !startup_i) begin
         boot_wait_reg <= 1'b1;
      end else if (boot_trig) begin
         boot_wait_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ls_prev_reg   <= LS_RST;
         vbus_prev_reg <= VBUS_BELOW_END;
         evt_prev_reg  <= EVT_NONE;
         id_prev_reg   <= 1'b0;
      end else begin
         ls_prev_reg   <= line_state;
         vbus_prev_reg <= vbus_enc;
         evt_prev_reg  <= evt_enc;
         id_prev_reg   <= id_i;
      end
   end

   // link bytes are only trusted when the link owns the bus, never in turnaround
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         link_byte_reg  <= DATA_RST;
         link_valid_reg <= 1'b0;
      end else begin
         link_valid_reg <= (state_reg == ST_IDLE);
         if (state_reg == ST_IDLE) begin
            link_byte_reg <= ulpi_data_i;
         end
      end
   end

   assign ulpi_dir_o        = dir_reg;
   assign ulpi_nxt_o        = nxt_reg;
   assign ulpi_data_o       = data_reg;
   assign ulpi_data_oe_n_o  = oe_n_reg;
   assign link_byte_o       = link_byte_reg;
   assign link_byte_valid_o = link_valid_reg;
endmodule

// file: core/urcg_pkg.sv
// shared constants and types for the receive-command generator
package urcg_pkg;
   localparam int         URCG_W       = 8;
   localparam int         URCG_BUF_DEP = 2;
   localparam int         URCG_PTR_W   = 1;
   localparam int         URCG_CNT_W   = 2;
   // status byte field positions
   localparam int         LS_LSB       = 0;
   localparam int         VBUS_LSB     = 2;
   localparam int         EVT_LSB      = 4;
   localparam int         ID_BIT       = 6;
   localparam int         ALT_BIT      = 7;
   // encoded vbus level
   localparam logic [1:0] VBUS_BELOW_END = 2'h0;
   localparam logic [1:0] VBUS_END_TO_SV = 2'h1;
   localparam logic [1:0] VBUS_SV_TO_VV  = 2'h2;
   localparam logic [1:0] VBUS_ABOVE_VV  = 2'h3;
   // encoded receive events
   localparam logic [1:0] EVT_NONE     = 2'h0;
   localparam logic [1:0] EVT_ACTIVE   = 2'h1;
   localparam logic [1:0] EVT_HOSTDISC = 2'h2;
   localparam logic [1:0] EVT_ERROR    = 2'h3;
   // reset values and the buffer's full count
   localparam logic [7:0] DATA_RST     = 8'h00;
   localparam logic [1:0] LS_RST       = 2'h0;
   localparam logic [1:0] CNT_FULL     = 2'h2;

   typedef enum {
      ST_START,
      ST_IDLE,
      ST_TURN_UP,
      ST_OWN,
      ST_TURN_DOWN
   } urcg_state_t;
endpackage

// file: core/urcg_rx_buf.sv
// two-entry buffer between the receiver and the bus
module urcg_rx_buf (
   input  wire logic                         clk_i,
   input  wire logic                         sys_rst_i,
   input  wire logic                         in_valid_i,
   input  wire logic [urcg_pkg::URCG_W-1:0]  in_data_i,
   output logic                              in_ready_o,
   output logic                              out_valid_o,
   output logic [urcg_pkg::URCG_W-1:0]       out_data_o,
   input  wire logic                         out_ready_i
);
   import urcg_pkg::*;

   logic [URCG_W-1:0]     mem_reg [URCG_BUF_DEP];
   logic [URCG_PTR_W-1:0] wr_ptr_reg;
   logic [URCG_PTR_W-1:0] rd_ptr_reg;
   logic [URCG_CNT_W-1:0] cnt_reg;
   logic [URCG_CNT_W-1:0] cnt_next;
   logic                  ready_reg;
   logic                  push;
   logic                  pop;

   assign push        = in_valid_i && ready_reg;
   assign pop         = out_ready_i && (cnt_reg != '0);
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o  = mem_reg[rd_ptr_reg];
   assign in_ready_o  = ready_reg;

   always_comb begin
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + 2'h1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 2'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   // ready is registered, so it looks at the next count to avoid overrun
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg    <= '0;
         ready_reg  <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         cnt_reg   <= cnt_next;
         ready_reg <= (cnt_next != CNT_FULL);
      end
   end
endmodule

// file: bench/urcg_checker.sv
// assertions on the status-byte generator's bus ports
module urcg_checker
   import urcg_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       sys_rst_i,
   input wire logic       ulpi_stp_i,
   input wire logic [7:0] ulpi_data_o,
   input wire logic       ulpi_data_oe_n_o,
   input wire logic       ulpi_dir_o,
   input wire logic       ulpi_nxt_o,
   input wire logic       sync_mode_i,
   input wire logic       tx_active_i,
   input wire logic       dp_rcv_i,
   input wire logic       dm_rcv_i,
   input wire logic       sess_end_i,
   input wire logic       sess_vld_i,
   input wire logic       vbus_vld_i,
   input wire logic       id_i,
   input wire logic       alt_int_i,
   input wire logic       rx_active_i,
   input wire logic       rx_error_i,
   input wire logic       host_disc_i
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic       hold_reg;
   logic [1:0] vb;
   logic [1:0] ev;
   assign vb = vbus_vld_i ? VBUS_ABOVE_VV : sess_vld_i ? VBUS_SV_TO_VV : !sess_end_i ? VBUS_END_TO_SV : VBUS_BELOW_END;
   assign ev = (rx_active_i && rx_error_i) ? EVT_ERROR : rx_active_i ? EVT_ACTIVE : host_disc_i ? EVT_HOSTDISC : EVT_NONE;
   // transmit hold as seen from the pins, so the idle triggers can exclude it
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || (ulpi_stp_i && !ulpi_dir_o && !tx_active_i)) hold_reg <= 1'b0;
      else if (tx_active_i) hold_reg <= 1'b1;
   end
   sequence idle_s;
      sync_mode_i && !hold_reg && !tx_active_i && !ulpi_dir_o && !$past(ulpi_dir_o);
   endsequence
   sequence status_s;
      !ulpi_data_oe_n_o && !ulpi_nxt_o;
   endsequence
   sequence take_s;
      ulpi_dir_o && ulpi_data_oe_n_o ##1 status_s;
   endsequence
   a_ls_take: assert property (idle_s ##0 ({dm_rcv_i, dp_rcv_i} != $past({dm_rcv_i, dp_rcv_i})) |=> take_s)
      else $error("line change did not take the bus");
   a_cmp_take: assert property (idle_s ##0 ({vb, id_i} != $past({vb, id_i})) |=> take_s)
      else $error("comparator change did not take the bus");
   a_rx_status: assert property (ulpi_dir_o && $past(ulpi_dir_o) && $past(rx_active_i) && $past(sync_mode_i)
      && !ulpi_nxt_o |-> !ulpi_data_oe_n_o) else $error("receive cycle without status byte");
   a_tx_hold: assert property (hold_reg && !ulpi_stp_i && !ulpi_dir_o |=> !ulpi_dir_o)
      else $error("bus taken during transmit hold");
   a_stp_send: assert property (hold_reg && ulpi_stp_i && !ulpi_dir_o && !$past(ulpi_dir_o) && sync_mode_i
      && !tx_active_i |=> take_s) else $error("no status byte after stop");
   a_drive_owned: assert property (!ulpi_data_oe_n_o |-> ulpi_dir_o && $past(ulpi_dir_o))
      else $error("data driven outside ownership");
   a_turn_quiet: assert property ($changed(ulpi_dir_o) |-> ulpi_data_oe_n_o)
      else $error("data driven in turnaround");
   a_ls_field: assert property (status_s |-> ulpi_data_o[1:0] == $past({dm_rcv_i, dp_rcv_i}))
      else $error("line state field wrong");
   a_vbus_field: assert property (status_s |-> ulpi_data_o[3:2] == $past(vb))
      else $error("vbus field wrong");
   a_evt_field: assert property (status_s |-> ulpi_data_o[5:4] == $past(ev))
      else $error("event field wrong");
   a_id_alt: assert property (status_s |-> ulpi_data_o[7:6] == $past({alt_int_i, id_i}))
      else $error("id or alternate field wrong");
endmodule

bind urcg_top urcg_checker urcg_checker_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ulpi_stp_i(ulpi_stp_i),
   .ulpi_data_o(ulpi_data_o), .ulpi_data_oe_n_o(ulpi_data_oe_n_o), .ulpi_dir_o(ulpi_dir_o), .ulpi_nxt_o(ulpi_nxt_o),
   .sync_mode_i(sync_mode_i), .tx_active_i(tx_active_i), .dp_rcv_i(dp_rcv_i), .dm_rcv_i(dm_rcv_i),
   .sess_end_i(sess_end_i), .sess_vld_i(sess_vld_i), .vbus_vld_i(vbus_vld_i), .id_i(id_i), .alt_int_i(alt_int_i),
   .rx_active_i(rx_active_i), .rx_error_i(rx_error_i), .host_disc_i(host_disc_i));

// file: bench/urcg_link_model.sv
// link controller model on the far side of the 8-bit bus
module urcg_link_model (
   input  wire logic       clk_i,
   input  wire logic       dir_i,
   input  wire logic       nxt_i,
   input  wire logic       oe_n_i,
   input  wire logic [7:0] data_i,
   input  wire logic       stp_req_i,
   output logic            stp_o,
   output logic [7:0]      data_o,
   output logic [7:0]      last_cmd_o,
   output int              n_cmd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       dir_q = 1'b1;
   logic [7:0] junk  = 8'h5a;
   initial n_cmd_o = 0;
   initial last_cmd_o = 8'h00;
   assign stp_o = stp_req_i;
   // a floating bus is modelled as a toggling pattern so stale values never look valid
   assign data_o = (!dir_i && !dir_q) ? 8'h00 : junk;
   always @(posedge clk_i) begin
      dir_q <= dir_i;
      junk <= ~junk;
      if (dir_i && dir_q && !oe_n_i && !nxt_i) begin
         n_cmd_o <= n_cmd_o + 1;
         last_cmd_o <= data_i;
      end
   end
endmodule

// file: bench/urcg_top_tb.sv
// self-checking bench for the status-byte generator
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t got %h exp %h", $time, (g), (e)); end end
module urcg_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import urcg_pkg::*;
   logic       clk_i = 0, rst = 1, stp_req = 0, startup = 1, sync = 1, lp_exit = 0, tx_act = 0;
   logic       dp = 0, dm = 0, s_end = 1, s_vld = 0, v_vld = 0, id = 0, alt = 0;
   logic       rx_act = 0, rx_err = 0, h_disc = 0, rx_vld = 0, rx_rdy, stp, dir, nxt, oe_n, lb_vld;
   logic [7:0] rx_dat = 8'h00, d_in, d_out, last_cmd, lb;
   int         n_cmd, n_mismatch = 0, total_checks = 0, cyc = 0;
   always #2 clk_i = ~clk_i;
   urcg_top urcg_top_inst (.clk_i(clk_i), .sys_rst_i(rst), .ulpi_stp_i(stp), .ulpi_data_i(d_in),
      .ulpi_data_o(d_out), .ulpi_data_oe_n_o(oe_n), .ulpi_dir_o(dir), .ulpi_nxt_o(nxt), .startup_i(startup),
      .sync_mode_i(sync), .lp_exit_i(lp_exit), .tx_active_i(tx_act), .dp_rcv_i(dp), .dm_rcv_i(dm),
      .sess_end_i(s_end), .sess_vld_i(s_vld), .vbus_vld_i(v_vld), .id_i(id), .alt_int_i(alt),
      .rx_active_i(rx_act), .rx_error_i(rx_err), .host_disc_i(h_disc), .rx_valid_i(rx_vld), .rx_data_i(rx_dat),
      .rx_ready_o(rx_rdy), .link_byte_o(lb), .link_byte_valid_o(lb_vld));
   urcg_link_model urcg_link_model_inst (.clk_i(clk_i), .dir_i(dir), .nxt_i(nxt), .oe_n_i(oe_n), .data_i(d_out),
      .stp_req_i(stp_req), .stp_o(stp), .data_o(d_in), .last_cmd_o(last_cmd), .n_cmd_o(n_cmd));
   function automatic logic [7:0] exp_cmd();
      logic [1:0] vb, ev;
      vb = v_vld ? VBUS_ABOVE_VV : s_vld ? VBUS_SV_TO_VV : !s_end ? VBUS_END_TO_SV : VBUS_BELOW_END;
      ev = (rx_act && rx_err) ? EVT_ERROR : rx_act ? EVT_ACTIVE : h_disc ? EVT_HOSTDISC : EVT_NONE;
      return {alt, id, ev, vb, dm, dp};
   endfunction
   task automatic step(); @(posedge clk_i); #1; endtask
   task automatic wait_cmd();
      int n0;
      n0 = n_cmd;
      for (int i = 0; i < 20 && n_cmd == n0; i++) step();
      `CHK(n_cmd, n0 + 1)
      `CHK(last_cmd, exp_cmd())
      `CHK(lb_vld, 1'b0)
   endtask
   // leave the bus idle so the next trigger starts from a known place
   task automatic settle();
      for (int i = 0; i < 20 && dir; i++) step();
      repeat (3) step();
   endtask
   task automatic t_start();
      repeat (3) step();
      `CHK(dir, 1'b1)
      startup = 0;
      wait_cmd();
      settle();
      `CHK(lb_vld, 1'b1)
      `CHK(lb, 8'h00)
      for (int i = 1; i < 5; i++) begin
         {dm, dp} = i[1:0];
         wait_cmd();
         settle();
      end
      $display("test start and line state done");
   endtask
   task automatic t_vbus();
      logic [2:0] tbl [5] = '{3'h0, 3'h2, 3'h6, 3'h3, 3'h1};
      for (int i = 0; i < 5; i++) begin
         {v_vld, s_vld, s_end} = tbl[i];
         wait_cmd();
         settle();
      end
      id = 1;
      alt = 1;
      wait_cmd();
      settle();
      alt = 0;
      id = 0;
      wait_cmd();
      settle();
      $display("test vbus and id done");
   endtask
   task automatic t_hold();
      int n0;
      tx_act = 1;
      step();
      tx_act = 0;
      n0 = n_cmd;
      dp = ~dp;
      id = 1;
      for (int i = 0; i < 6; i++) begin
         step();
         `CHK(dir, 1'b0)
      end
      stp_req = 1;
      step();
      stp_req = 0;
      wait_cmd();
      settle();
      `CHK(n_cmd, n0 + 1)
      id = 0;
      wait_cmd();
      settle();
      lp_exit = 1;
      step();
      lp_exit = 0;
      wait_cmd();
      settle();
      $display("test hold and exit done");
   endtask
   task automatic t_rx();
      logic [7:0] got [$];
      h_disc = 1;
      wait_cmd();
      settle();
      sync = 0;
      dp = ~dp;
      repeat (6) step();
      `CHK(dir, 1'b0)
      rx_vld = 1;
      for (int k = 0; k < 3; k++) begin
         rx_dat = 8'ha1 + k[7:0];
         for (int i = 0; i < 20 && !rx_rdy && k < 2; i++) step();
         step();
      end
      `CHK(rx_rdy, 1'b0)
      rx_vld = 0;
      sync = 1;
      rx_act = 1;
      for (int i = 0; i < 16; i++) begin
         step();
         if (dir && !oe_n && nxt) got.push_back(d_out);
         else if (dir && !oe_n) `CHK(d_out, exp_cmd())
         if (i == 8) rx_err = 1;
      end
      `CHK(got.size(), 2)
      `CHK(got[0], 8'ha1)
      `CHK(got[1], 8'ha2)
      rx_act = 0;
      rx_err = 0;
      h_disc = 0;
      settle();
      $display("test receive done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // the whole run is under two hundred cycles; the ceiling leaves wide margin
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      repeat (5) step();
      rst = 0;
      t_start();
      t_vbus();
      t_hold();
      t_rx();
      summarize();
   end
endmodule
